// file: src/cio_core.sv
/*
 * i/o object dictionary core: service-data server, lamp outputs,
 * event-driven button and joystick process-data messages.
 * assumes a can controller on the same clock that hands over whole
 * frames and accepts frames with a valid/ready handshake.
 */
`include "cio_regs.svh"
module cio_core
    import cio_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // received frames from the can controller
    input wire logic rx_valid_i,
    input wire cio_frame_t rx_frame_i,
    output logic rx_ready_o,
    // frames to the can controller
    output logic tx_valid_o,
    output cio_frame_t tx_frame_o,
    input wire logic tx_ready_i,
    // input pins
    input wire logic [15:0] switch_i,
    input wire logic [3:0] four_way_i,
    input wire logic [1:0] stick_button_i,
    input wire logic [3:0] stick_dir_i,
    input wire logic stick_fitted_i,
    input wire logic [`CIO_LAMP_W-1:0] lamp_sense_i,
    // output pins
    output logic [19:0] led_drive_o,
    output logic [3:0] switch_lamp_output_o
);
    cio_core_t core_reg; // whole block state
    cio_core_t core_next; // its next value
    logic [50:0] pins_sync; // synchronised pin vector
    logic [15:0] sw_s; // switches
    logic [3:0] fw_s; // four-way switch
    logic [1:0] btn_s; // stick buttons
    logic [3:0] dir_s; // stick directions n,o,s,w
    logic fit_s; // digital stick fitted
    logic [`CIO_LAMP_W-1:0] sense_s; // lamp read-back
    logic [3:0] dir_m; // directions gated by fitted
    logic [31:0] sw_word; // switch group process word
    logic [7:0] stk_word; // stick process word
    logic sdo_take; // service request taken this cycle
    logic btn_chg; // switch word changed
    logic stk_chg; // stick word changed
    cio_od_ans_t ans; // dictionary answer

    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    // every pin is asynchronous to the clock, so all pass two flops
    cio_sync #(
        .W(51)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pin_i({lamp_sense_i, stick_fitted_i, stick_dir_i, stick_button_i,
            four_way_i, switch_i}),
        .sync_o(pins_sync)
    );
    assign {sense_s, fit_s, dir_s, btn_s, fw_s, sw_s} = pins_sync;

    // ----------------------------------------
    // process words
    // ----------------------------------------
    // directions mean nothing without a digital stick, so they read 0
    assign dir_m = dir_s & {4{fit_s}};
    // active-high inputs pass straight through
    assign sw_word = {6'h00, dir_m, btn_s, fw_s, sw_s};
    assign stk_word = {1'b0, btn_s, 1'b0, dir_m};

    // ----------------------------------------
    // dictionary lookup on the latched request
    // ----------------------------------------
    cio_od_lookup u_od (
        .cmd_i(core_reg.cmd),
        .idx_i(core_reg.idx),
        .sub_i(core_reg.sub),
        .sw_word_i(sw_word),
        .stk_word_i(stk_word),
        .lamp_set_i(core_reg.lamp),
        .lamp_sense_i(sense_s),
        .ans_o(ans)
    );

    // ----------------------------------------
    // handshake decode
    // ----------------------------------------
    // frames are accepted only while idle; other ids are dropped
    assign rx_ready_o = (core_reg.st == CIO_IDLE);
    assign sdo_take = rx_valid_i && rx_ready_o &&
        (rx_frame_i.id == `CIO_SDO_RX_ID) &&
        (rx_frame_i.dlc == `CIO_DLC_FULL);
    assign btn_chg = (sw_word != core_reg.sw_prev);
    assign stk_chg = (stk_word != core_reg.stk_prev);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        core_next = core_reg;
        // change detection; a change sets the pending flag
        if (btn_chg) begin
            core_next.sw_prev = sw_word;
            core_next.btn_pend = 1'b1;
        end
        if (stk_chg) begin
            core_next.stk_prev = stk_word;
            core_next.stk_pend = 1'b1;
        end
        case (core_reg.st)
            CIO_IDLE: begin
                if (sdo_take) begin
                    // service requests win over process messages
                    core_next.cmd = rx_frame_i.data[7:0];
                    core_next.idx = rx_frame_i.data[23:8];
                    core_next.sub = rx_frame_i.data[31:24];
                    core_next.wdata = rx_frame_i.data[63:32];
                    core_next.st = CIO_EXEC;
                end else if (core_reg.btn_pend) begin
                    // a change in this very cycle keeps the flag set
                    core_next.btn_pend = btn_chg;
                    core_next.tx.id = `CIO_PDO_BTN_ID;
                    core_next.tx.dlc = `CIO_DLC_BTN;
                    core_next.tx.data = {32'h00000000, sw_word};
                    core_next.st = CIO_SEND;
                end else if (core_reg.stk_pend) begin
                    core_next.stk_pend = stk_chg;
                    core_next.tx.id = `CIO_PDO_STK_ID;
                    core_next.tx.dlc = `CIO_DLC_STK;
                    core_next.tx.data = {56'h0, stk_word};
                    core_next.st = CIO_SEND;
                end
            end
            CIO_EXEC: begin
                // every reply is a full eight-byte frame
                core_next.tx.id = `CIO_SDO_TX_ID;
                core_next.tx.dlc = `CIO_DLC_FULL;
                if (ans.fail) begin
                    // abort leaves the lamp state as it was
                    core_next.tx.data = {ans.abort, core_reg.sub,
                        core_reg.idx, `CIO_RSP_ABORT};
                end else if (ans.lamp_we) begin
                    // upper byte is dropped; master keeps it zero
                    core_next.lamp = core_reg.wdata[`CIO_LAMP_W-1:0];
                    core_next.tx.data = {32'h00000000, core_reg.sub,
                        core_reg.idx, `CIO_RSP_DL};
                end else begin
                    // smaller values go out widened to four bytes
                    core_next.tx.data = {ans.value, core_reg.sub,
                        core_reg.idx, `CIO_RSP_UPLOAD};
                end
                core_next.st = CIO_SEND;
            end
            CIO_SEND: begin
                // hold the frame until the controller takes it
                if (tx_ready_i) begin
                    core_next.st = CIO_IDLE;
                end
            end
            default: core_next.st = CIO_IDLE;
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            core_reg <= '0;
            core_reg.st <= CIO_IDLE;
            core_reg.lamp <= `CIO_LAMP_RST;
        end else begin
            core_reg <= core_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign tx_valid_o = (core_reg.st == CIO_SEND);
    assign tx_frame_o = core_reg.tx;
    // one means lit; lamps 1..4 sit on bits 20..23
    assign led_drive_o = core_reg.lamp[19:0];
    assign switch_lamp_output_o = core_reg.lamp[23:20];

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // a taken request gets its reply on the reply id two cycles later
    a_reply_id_timing: assert property (
        sdo_take |-> ##2 (tx_valid_o && tx_frame_o.id == `CIO_SDO_TX_ID &&
            tx_frame_o.dlc == `CIO_DLC_FULL))
        else $error("reply missing or on wrong id");

    // a good lamp write shows on the pins two cycles after it is taken
    a_lamp_write_drive: assert property (
        (sdo_take && rx_frame_i.data[7:0] == `CIO_CMD_DL4 &&
            rx_frame_i.data[23:8] == `CIO_IDX_LAMP &&
            rx_frame_i.data[31:24] == `CIO_SUB_SET) |->
        ##2 ({switch_lamp_output_o, led_drive_o} ==
            $past(rx_frame_i.data[55:32], 2)))
        else $error("lamp write not driven");

    // writes anywhere but the lamp group abort and keep the lamps
    a_ro_write_abort: assert property (
        (sdo_take && rx_frame_i.data[7:0] == `CIO_CMD_DL4 &&
            rx_frame_i.data[23:8] != `CIO_IDX_LAMP) |->
        ##2 (tx_frame_o.data[7:0] == `CIO_RSP_ABORT &&
            $stable(led_drive_o) && $stable(switch_lamp_output_o)))
        else $error("write to read-only entry not aborted");

    // a switch change reaches the bus within a bounded wait
    a_btn_event_sent: assert property (
        (btn_chg && core_reg.st == CIO_IDLE && !rx_valid_i && tx_ready_i) |->
        ##[1:3] (tx_valid_o && tx_frame_o.id == `CIO_PDO_BTN_ID))
        else $error("switch change not sent");

    // no process message without a preceding change
    a_no_cyclic_pdo: assert property (
        (core_reg.st == CIO_IDLE && !sdo_take && !core_reg.btn_pend &&
            !core_reg.stk_pend) |=> (core_reg.st != CIO_SEND))
        else $error("process message sent without a change");

    // reserved switch bits are zero in every button message
    a_sw_reserved_zero: assert property (
        (tx_valid_o && tx_frame_o.id == `CIO_PDO_BTN_ID) |->
        (tx_frame_o.data[31:26] == 6'h00 && tx_frame_o.dlc == `CIO_DLC_BTN &&
            tx_frame_o.data[63:32] == 32'h00000000))
        else $error("reserved switch bits set");

    // stick message carries one byte with bits 4 and 7 clear
    a_stk_word_shape: assert property (
        (tx_valid_o && tx_frame_o.id == `CIO_PDO_STK_ID) |->
        (tx_frame_o.dlc == `CIO_DLC_STK && !tx_frame_o.data[4] &&
            !tx_frame_o.data[7]))
        else $error("stick word malformed");

    // mapping entry one reads the button mapping
    a_map_read_value: assert property (
        (tx_valid_o && tx_frame_o.id == `CIO_SDO_TX_ID &&
            core_reg.cmd == `CIO_CMD_UPLOAD &&
            core_reg.idx == `CIO_IDX_TXMAP && core_reg.sub == 8'h01) |->
        (tx_frame_o.data[63:32] == `CIO_MAP_BTN))
        else $error("mapping entry wrong");

    // count entries read 26 in each group
    a_count_read_value: assert property (
        (tx_valid_o && tx_frame_o.id == `CIO_SDO_TX_ID &&
            core_reg.cmd == `CIO_CMD_UPLOAD &&
            core_reg.sub == `CIO_SUB_COUNT &&
            (core_reg.idx == `CIO_IDX_LAMP || core_reg.idx == `CIO_IDX_INPUT ||
            core_reg.idx == `CIO_IDX_STICK)) |->
        (tx_frame_o.data[63:32] == `CIO_GRP_COUNT))
        else $error("count entry wrong");

    // successful uploads always answer with the four-byte command
    a_upload_four_byte: assert property (
        (core_reg.st == CIO_EXEC && core_reg.cmd == `CIO_CMD_UPLOAD &&
            !ans.fail) |=> (tx_frame_o.data[7:0] == `CIO_RSP_UPLOAD))
        else $error("upload reply not four bytes");

    // ----------------------------------------
    // handshake, abort and stick message guards
    // ----------------------------------------
    // a frame offered to a slow controller must not move under it,
    // otherwise the controller could send a torn mix of two frames
    a_tx_frame_held: assert property (
        (tx_valid_o && !tx_ready_i) |=>
        (tx_valid_o && $stable(tx_frame_o)))
        else $error("offered frame changed before it was taken");

    // a refused request must leave the lamp word untouched
    a_abort_keeps_lamp: assert property (
        (core_reg.st == CIO_EXEC && ans.fail) |=> $stable(core_reg.lamp))
        else $error("aborted request changed the lamps");

    // stick message carries nothing beyond its single byte
    a_stk_upper_zero: assert property (
        (tx_valid_o && tx_frame_o.id == `CIO_PDO_STK_ID) |->
        (tx_frame_o.data[63:8] == 56'h0))
        else $error("stick message upper bytes set");
endmodule

// file: common/cio_regs.svh
/*
 * constants of the i/o object dictionary: identifiers, indices,
 * sub-indices, fixed values, service-data command and abort codes.
 * assumes inclusion by bare name from the package and the modules.
 */
`ifndef CIO_REGS_SVH
`define CIO_REGS_SVH
// ----------------------------------------
// message identifiers
// ----------------------------------------
`define CIO_SDO_RX_ID 11'h629
`define CIO_SDO_TX_ID 11'h5a9
`define CIO_PDO_BTN_ID 11'h1a9
`define CIO_PDO_STK_ID 11'h2a9
`define CIO_DLC_FULL 4'h8
`define CIO_DLC_BTN 4'h4
`define CIO_DLC_STK 4'h1
// ----------------------------------------
// object indices and sub-indices
// ----------------------------------------
`define CIO_IDX_TXMAP 16'h1a00
`define CIO_IDX_FEAT 16'h2000
`define CIO_IDX_LAMP 16'h2100
`define CIO_IDX_INPUT 16'h2200
`define CIO_IDX_STICK 16'h2300
`define CIO_SUB_VALUE 8'h04
`define CIO_SUB_SET 8'h05
`define CIO_SUB_COUNT 8'h06
// ----------------------------------------
// fixed values and reset values
// ----------------------------------------
`define CIO_MAP_CNT 32'h00000001
`define CIO_MAP_BTN 32'h22000420
`define CIO_MAP_STK 32'h23000408
`define CIO_FEAT_VAL 32'h00000000
`define CIO_GRP_ENTRIES 32'h00000006
`define CIO_GRP_COUNT 32'h0000001a
`define CIO_LAMP_W 24
`define CIO_LAMP_RST 24'h000000
// ----------------------------------------
// service-data commands and aborts
// ----------------------------------------
`define CIO_CMD_UPLOAD 8'h40
`define CIO_CMD_DL4 8'h23
`define CIO_RSP_UPLOAD 8'h43
`define CIO_RSP_DL 8'h60
`define CIO_RSP_ABORT 8'h80
`define CIO_ABT_CMD 32'h05040001
`define CIO_ABT_LEN 32'h06070010
`define CIO_ABT_RO 32'h06010002
`define CIO_ABT_SUB 32'h06090011
`define CIO_ABT_OBJ 32'h06020000
`endif

// file: common/cio_pkg.sv
/*
 * types of the i/o object dictionary: can frame, fsm states,
 * dictionary answer and the core state record.
 * assumes cio_regs.svh on the include path.
 */
`include "cio_regs.svh"
package cio_pkg;
    // one can frame; data byte k sits in bits 8k+7..8k
    typedef struct packed {
        logic [10:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } cio_frame_t;
    // one-hot fsm states
    typedef enum logic [2:0] {
        CIO_IDLE = 3'b001,
        CIO_EXEC = 3'b010,
        CIO_SEND = 3'b100
    } cio_state_t;
    // answer of the dictionary lookup
    typedef struct packed {
        logic [31:0] value;
        logic [31:0] abort;
        logic fail;
        logic lamp_we;
    } cio_od_ans_t;
    // whole state of the core
    typedef struct packed {
        cio_state_t st;
        logic [`CIO_LAMP_W-1:0] lamp;
        logic [31:0] sw_prev;
        logic [7:0] stk_prev;
        logic btn_pend;
        logic stk_pend;
        logic [7:0] cmd;
        logic [15:0] idx;
        logic [7:0] sub;
        logic [31:0] wdata;
        cio_frame_t tx;
    } cio_core_t;
endpackage

// file: src/cio_sync.sv
/*
 * two-flop synchroniser for a vector of pin inputs.
 * assumes bits are independent levels; no bus coherence is given.
 */
module cio_sync
    import cio_pkg::*;
#(
    parameter int W = 51
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // pins in, synchronised out
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    // both stages in one record; s1 is read only by s2
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cio_sync_t;
    cio_sync_t sync_reg;
    cio_sync_t sync_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        sync_next.s1 = pin_i;
        sync_next.s2 = sync_reg.s1;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg.s2;
endmodule

// file: src/cio_od_lookup.sv
/*
 * combinational object-dictionary lookup for one service-data request.
 * assumes the caller registers the answer and applies the lamp write.
 */
`include "cio_regs.svh"
module cio_od_lookup
    import cio_pkg::*;
(
    // request
    input wire logic [7:0] cmd_i,
    input wire logic [15:0] idx_i,
    input wire logic [7:0] sub_i,
    // live values
    input wire logic [31:0] sw_word_i,
    input wire logic [7:0] stk_word_i,
    input wire logic [`CIO_LAMP_W-1:0] lamp_set_i,
    input wire logic [`CIO_LAMP_W-1:0] lamp_sense_i,
    // answer
    output cio_od_ans_t ans_o
);
    logic obj_ok; // index exists
    logic sub_ok; // sub-index exists
    logic wr_ok; // sub-index is writable
    logic [31:0] val; // read value
    logic is_grp; // one of the three groups

    // ----------------------------------------
    // value decode
    // ----------------------------------------
    always_comb begin
        obj_ok = 1'b1;
        sub_ok = 1'b1;
        wr_ok = 1'b0;
        val = '0;
        is_grp = (idx_i == `CIO_IDX_LAMP) || (idx_i == `CIO_IDX_INPUT) ||
            (idx_i == `CIO_IDX_STICK);
        if (idx_i == `CIO_IDX_TXMAP) begin
            case (sub_i)
                8'h00: val = `CIO_MAP_CNT;
                8'h01: val = `CIO_MAP_BTN;
                8'h02: val = `CIO_MAP_STK;
                default: sub_ok = 1'b0;
            endcase
        end else if (idx_i == `CIO_IDX_FEAT) begin
            // compatibility only, never writable
            sub_ok = (sub_i == 8'h00);
            val = `CIO_FEAT_VAL;
        end else if (is_grp) begin
            case (sub_i)
                8'h00: val = `CIO_GRP_ENTRIES;
                8'h01, 8'h02, 8'h03: val = '0;
                `CIO_SUB_VALUE: begin
                    if (idx_i == `CIO_IDX_LAMP) begin
                        val = {8'h00, lamp_sense_i};
                    end else if (idx_i == `CIO_IDX_INPUT) begin
                        val = sw_word_i;
                    end else begin
                        val = {24'h000000, stk_word_i};
                    end
                end
                `CIO_SUB_SET: begin
                    // lamp set word is the only writable entry
                    if (idx_i == `CIO_IDX_LAMP) begin
                        val = {8'h00, lamp_set_i};
                        wr_ok = 1'b1;
                    end else begin
                        val = '0;
                    end
                end
                `CIO_SUB_COUNT: val = `CIO_GRP_COUNT;
                default: sub_ok = 1'b0;
            endcase
        end else begin
            obj_ok = 1'b0;
        end
    end

    // ----------------------------------------
    // verdict: object, sub-index, command, access
    // ----------------------------------------
    always_comb begin
        ans_o.value = val;
        ans_o.abort = '0;
        ans_o.fail = 1'b1;
        ans_o.lamp_we = 1'b0;
        if (!obj_ok) begin
            ans_o.abort = `CIO_ABT_OBJ;
        end else if (!sub_ok) begin
            ans_o.abort = `CIO_ABT_SUB;
        end else if (cmd_i == `CIO_CMD_UPLOAD) begin
            ans_o.fail = 1'b0;
        end else if (cmd_i[7:5] == 3'b001) begin
            // downloads: only four-byte expedited into a writable entry
            if (cmd_i != `CIO_CMD_DL4) begin
                ans_o.abort = `CIO_ABT_LEN;
            end else if (!wr_ok) begin
                ans_o.abort = `CIO_ABT_RO;
            end else begin
                ans_o.fail = 1'b0;
                ans_o.lamp_we = 1'b1;
            end
        end else begin
            ans_o.abort = `CIO_ABT_CMD;
        end
    end
endmodule

// file: tb/cio_can_model.sv
/*
 * can controller model on the far side of the dictionary core.
 * assumes the core's frame handshake and one shared clock.
 */
`include "cio_regs.svh"
module cio_can_model
    import cio_pkg::*;
(
    // clock
    input wire logic clock_i,
    // frames towards the core
    output logic rx_valid_o,
    output cio_frame_t rx_frame_o,
    input wire logic rx_ready_i,
    // frames from the core
    input wire logic tx_valid_i,
    input wire cio_frame_t tx_frame_i,
    output logic tx_ready_o
);
    cio_frame_t got[$]; // frames taken from the core
    int stall = 0; // cycles to hold off the next frame, a slow controller
    initial begin
        rx_valid_o = 1'b0;
        rx_frame_o = '1;
        tx_ready_o = 1'b1;
    end
    // ready drops while a stall is counted down
    always @(negedge clock_i) begin
        if (tx_valid_i && stall > 0) begin
            stall--;
        end
        tx_ready_o = (stall == 0);
    end
    // collect every frame handed over
    always @(posedge clock_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_frame_i);
        end
    end
    // one service-data request, held until the core takes it
    task automatic sdo(input logic [7:0] cmd, input logic [15:0] idx,
                       input logic [7:0] sub, input logic [31:0] val);
        if (idx == `CIO_IDX_LAMP) begin
            val[31:24] = 8'h00;
        end
        if (idx == `CIO_IDX_INPUT) begin
            val[31:26] = 6'h00;
        end
        @(negedge clock_i);
        rx_frame_o = '{`CIO_SDO_RX_ID, `CIO_DLC_FULL, {val, sub, idx, cmd}};
        rx_valid_o = 1'b1;
        for (int i = 0; i < 100 && !rx_ready_i; i++) begin
            @(negedge clock_i);
        end
        @(negedge clock_i);
        rx_valid_o = 1'b0;
        // released lines show the inverse, never the last value
        rx_frame_o = ~rx_frame_o;
    endtask
endmodule

// file: tb/can_io_object_dictionary_bench.sv
/*
 * self-checking bench of the i/o dictionary core.
 * assumes cio_can_model as the controller; pins driven at falling edge.
 */
`include "cio_regs.svh"
module can_io_object_dictionary_bench
    import cio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clock_i, rst_i, rx_valid, rx_ready, tx_valid, tx_ready, stick_fit;
    cio_frame_t rx_frame, tx_frame, f;
    logic [15:0] sw_pins;
    logic [3:0] four_way, stick_dir, sw_lamp;
    logic [1:0] stick_btn;
    logic [23:0] lamp_sense;
    logic [19:0] led_drive;
    int failures = 0;
    int n_checks = 0;
    cio_core dut_u (.clock_i(clock_i), .rst_i(rst_i), .rx_valid_i(rx_valid),
        .rx_frame_i(rx_frame), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
        .tx_frame_o(tx_frame), .tx_ready_i(tx_ready), .switch_i(sw_pins),
        .four_way_i(four_way), .stick_button_i(stick_btn), .stick_dir_i(stick_dir),
        .stick_fitted_i(stick_fit), .lamp_sense_i(lamp_sense),
        .led_drive_o(led_drive), .switch_lamp_output_o(sw_lamp));
    cio_can_model can_u (.clock_i(clock_i), .rx_valid_o(rx_valid), .rx_frame_o(rx_frame),
        .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_frame_i(tx_frame),
        .tx_ready_o(tx_ready));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // bounded wait for the next frame; a hang ends the run
    task automatic next_frame();
        for (int i = 0; i < 300 && can_u.got.size() == 0; i++) begin
            @(negedge clock_i);
        end
        if (can_u.got.size() == 0) begin
            failures++;
            stop_test();
        end else begin
            f = can_u.got.pop_front();
        end
    endtask
    // request, then compare the whole reply frame
    task automatic sdo_chk(input logic [7:0] cmd, input logic [15:0] idx,
            input logic [7:0] sub, input logic [31:0] val, input logic [7:0] rsp,
            input logic [31:0] exp);
        can_u.sdo(cmd, idx, sub, val);
        next_frame();
        check(f, {`CIO_SDO_TX_ID, `CIO_DLC_FULL, exp, sub, idx, rsp});
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
        sdo_chk(`CIO_CMD_UPLOAD, idx, sub, 32'h0, `CIO_RSP_UPLOAD, exp);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_table();
        rd(16'h1a00, 8'h01, 32'h22000420);
        rd(16'h1a00, 8'h02, 32'h23000408);
        rd(16'h2100, 8'h00, 32'h6);
        rd(16'h2100, 8'h06, 32'h1a);
        rd(16'h2200, 8'h06, 32'h1a);
        rd(16'h2300, 8'h06, 32'h1a);
        rd(16'h2200, 8'h01, 32'h0);
        rd(16'h2300, 8'h05, 32'h0);
        rd(16'h2000, 8'h00, `CIO_FEAT_VAL);
    endtask
    // lamp write with a stalling controller, then read-back of sensed lamps
    task automatic t_lamp();
        can_u.stall = 3;
        sdo_chk(`CIO_CMD_DL4, 16'h2100, 8'h05, 32'h00abcdef, `CIO_RSP_DL, 32'h0);
        check(led_drive, 20'hbcdef);
        check(sw_lamp, 4'ha);
        rd(16'h2100, 8'h05, 32'h00abcdef);
        lamp_sense = 24'h5a5a5a;
        repeat (4) @(negedge clock_i);
        rd(16'h2100, 8'h04, 32'h005a5a5a);
    endtask
    // refused accesses leave the led drive as it was
    task automatic t_abort();
        sdo_chk(`CIO_CMD_DL4, 16'h2200, 8'h04, 32'h1, `CIO_RSP_ABORT, `CIO_ABT_RO);
        sdo_chk(`CIO_CMD_DL4, 16'h2000, 8'h00, 32'h1, `CIO_RSP_ABORT, `CIO_ABT_RO);
        sdo_chk(`CIO_CMD_DL4, 16'h2300, 8'h04, 32'h1, `CIO_RSP_ABORT, `CIO_ABT_RO);
        sdo_chk(`CIO_CMD_UPLOAD, 16'h2100, 8'h07, 32'h0, `CIO_RSP_ABORT, `CIO_ABT_SUB);
        sdo_chk(`CIO_CMD_UPLOAD, 16'h2500, 8'h00, 32'h0, `CIO_RSP_ABORT, `CIO_ABT_OBJ);
        sdo_chk(8'h2b, 16'h2100, 8'h05, 32'h0, `CIO_RSP_ABORT, `CIO_ABT_LEN);
        sdo_chk(8'h99, 16'h2100, 8'h05, 32'h0, `CIO_RSP_ABORT, `CIO_ABT_CMD);
        check(led_drive, 20'hbcdef);
    endtask
    // pins change: one button and one stick message each, then silence
    task automatic events(input logic fit);
        logic [31:0] w;
        logic [7:0] s;
        @(negedge clock_i);
        stick_fit = fit;
        w = {6'h00, stick_dir & {4{fit}}, stick_btn, four_way, sw_pins};
        s = {1'b0, stick_btn, 1'b0, stick_dir & {4{fit}}};
        next_frame();
        check({f.id, f.dlc, f.data[31:0]}, {`CIO_PDO_BTN_ID, `CIO_DLC_BTN, w});
        next_frame();
        check({f.id, f.dlc, f.data[7:0]}, {`CIO_PDO_STK_ID, `CIO_DLC_STK, s});
        repeat (40) @(negedge clock_i);
        check(can_u.got.size(), 0);
        rd(16'h2200, 8'h04, w);
        rd(16'h2300, 8'h04, {24'h0, s});
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_i = 1'b1;
        {sw_pins, four_way, stick_btn, stick_dir, stick_fit, lamp_sense} = '0;
        repeat (20) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (10) @(negedge clock_i);
        check({led_drive, sw_lamp, tx_valid, can_u.got.size()}, 0);
        t_table();
        t_lamp();
        t_abort();
        // fitted flag moves with the pins, so the words change only once
        {sw_pins, four_way, stick_btn, stick_dir, stick_fit} = {16'h8001, 4'h5, 2'h2, 4'h9, 1'b1};
        events(1'b1);
        events(1'b0);
        stop_test();
    end
endmodule
